//--- pkg/adcb_defs.vh
`ifndef ADCB_DEFS_VH
`define ADCB_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADCB_ADDR_BURNOUT   4'h0
`define ADCB_ADDR_BIAS      4'h1
`define ADCB_ADDR_MONITOR   4'h2
`define ADCB_ADDR_GAINRATE  4'h3
`define ADCB_ADDR_OFC_LOW   4'h4
`define ADCB_ADDR_OFC_MID   4'h5
`define ADCB_ADDR_OFC_HIGH  4'h6
`define ADCB_ADDR_FSC_LOW   4'h7
`define ADCB_ADDR_FSC_MID   4'h8
`define ADCB_ADDR_FSC_HIGH  4'h9
`define ADCB_ADDR_REVISION  4'hA

// ****************************************
// Field positions
// ****************************************
`define ADCB_BURNOUT_MSB    7
`define ADCB_BURNOUT_LSB    6
`define ADCB_OSC_FLAG_BIT   7
`define ADCB_GAIN_MSB       6
`define ADCB_GAIN_LSB       4
`define ADCB_RATE_MSB       3
`define ADCB_RATE_LSB       0
`define ADCB_REV_MSB        7
`define ADCB_REV_LSB        4
`define ADCB_MODE_BIT       3

// ****************************************
// Reset values and fixed patterns
// ****************************************
`define ADCB_BURNOUT_RST    2'h0
`define ADCB_BURNOUT_FILL   6'h01
`define ADCB_BIAS_RST       2'h0
`define ADCB_MONITOR_RST    3'h0
`define ADCB_GAIN_RST       3'h0
`define ADCB_RATE_RST       4'h0
`define ADCB_OFC_RST        24'h000000
`define ADCB_MODE_RST       1'h0
`define ADCB_REVISION_CODE  4'h5

// ****************************************
// Monitor codes and rate limits
// ****************************************
`define ADCB_MON_NORMAL     3'h0
`define ADCB_MON_OFFSET     3'h1
`define ADCB_MON_GAINCAL    3'h2
`define ADCB_MON_TEMP       3'h3
`define ADCB_RATE_MAX_CODE  4'h9
`define ADCB_RATE_MAX_SPS   11'h7D0

// ****************************************
// Full-scale trim per gain code
// ****************************************
`define ADCB_TRIM_G0        24'h400000
`define ADCB_TRIM_G1        24'h400000
`define ADCB_TRIM_G2        24'h400000
`define ADCB_TRIM_G3        24'h400000
`define ADCB_TRIM_G4        24'h400000
`define ADCB_TRIM_G5        24'h400000
`define ADCB_TRIM_G6        24'h400000
`define ADCB_TRIM_G7        24'h400000

`endif

//--- hw/adcb_trim_rom.v
`include "adcb_defs.vh"
`default_nettype none

// ****************************************
// Factory full-scale trim store
// ****************************************
module adcb_trim_rom
(
  // Clock and reset
  input  wire        core_clk_in,
  input  wire        rst_n_in,
  input  wire        core_ce_in,
  // Read port
  input  wire        rd_en_in,
  input  wire [2:0]  gain_in,
  output reg  [23:0] trim_out
);

  // Trim value for one gain code
  function [23:0] trim_of;
    input [2:0] code;
    begin
      case (code)
        3'h0:    trim_of = `ADCB_TRIM_G0;
        3'h1:    trim_of = `ADCB_TRIM_G1;
        3'h2:    trim_of = `ADCB_TRIM_G2;
        3'h3:    trim_of = `ADCB_TRIM_G3;
        3'h4:    trim_of = `ADCB_TRIM_G4;
        3'h5:    trim_of = `ADCB_TRIM_G5;
        3'h6:    trim_of = `ADCB_TRIM_G6;
        default: trim_of = `ADCB_TRIM_G7;
      endcase
    end
  endfunction

  // Registered read, one cycle latency
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trim_out <= `ADCB_TRIM_G0;
    end
    else if (core_ce_in && rd_en_in)
    begin
      trim_out <= trim_of(gain_in);
    end
  end

endmodule

`default_nettype wire

//--- hw/adcb_register_bank.v
`include "adcb_defs.vh"
`default_nettype none

module adcb_register_bank
#(
  parameter [3:0] REVISION = `ADCB_REVISION_CODE  // Arbitrary value
)
(
  // Clock, reset, enable
  input  wire        core_clk_in,
  input  wire        rst_n_in,
  input  wire        core_ce_in,
  // Register access port
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [3:0]  reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  output reg  [7:0]  reg_rdata_out,
  // Oscillator source pin
  input  wire        ext_osc_in,
  // Conversion and serial status
  input  wire        conv_done_in,
  input  wire        ready_clear_in,
  input  wire        shared_clear_in,
  input  wire        cs_active_in,
  input  wire        shift_active_in,
  input  wire        dout_data_in,
  // Ready pins
  output reg         data_ready_pin_n_out,
  output reg         shared_output_ready_pin_out,
  output reg         shared_output_ready_pin_oe_out,
  // Analog front end control
  output reg  [1:0]  burnout_current_select_out,
  output reg  [13:0] burnout_current_na_out,
  output reg  [1:0]  midsupply_bias_enable_out,
  output reg  [3:0]  input_connection_out,
  output reg  [2:0]  effective_gain_code_out,
  output reg  [7:0]  gain_factor_out,
  output reg  [3:0]  output_rate_select_out,
  output reg  [10:0] output_rate_sps_out,
  output reg  [23:0] offset_coefficient_out,
  output reg  [23:0] fullscale_coefficient_out
);

  // ****************************************
  // Local constants
  // ****************************************
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_READY = 3'h2;
  localparam [2:0] ST_PULSE = 3'h4;

  // ****************************************
  // Functions
  // ****************************************

  // Ready pin sequencer shared by both pins
  function [2:0] ready_next;
    input [2:0] state;
    input       done;
    input       clear;
    begin
      case (state)
        ST_IDLE:
        begin
          ready_next = done ? ST_READY : ST_IDLE;
        end
        ST_READY:
        begin
          if (done)
            ready_next = ST_PULSE;
          else if (clear)
            ready_next = ST_IDLE;
          else
            ready_next = ST_READY;
        end
        ST_PULSE:
        begin
          ready_next = ST_READY;
        end
        default:
        begin
          ready_next = ST_IDLE;
        end
      endcase
    end
  endfunction

  // Pin level for a sequencer state, low means ready
  function ready_level;
    input [2:0] state;
    begin
      ready_level = (state != ST_READY);
    end
  endfunction

  // Samples per second for a rate code
  function [10:0] rate_sps;
    input [3:0] code;
    begin
      case (code)
        4'h0:    rate_sps = 11'h005;
        4'h1:    rate_sps = 11'h00A;
        4'h2:    rate_sps = 11'h014;
        4'h3:    rate_sps = 11'h028;
        4'h4:    rate_sps = 11'h050;
        4'h5:    rate_sps = 11'h0A0;
        4'h6:    rate_sps = 11'h140;
        4'h7:    rate_sps = 11'h280;
        4'h8:    rate_sps = 11'h3E8;
        default: rate_sps = `ADCB_RATE_MAX_SPS;
      endcase
    end
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  reg        osc_meta;
  reg        osc_sync;
  reg [1:0]  burnout_sel;
  reg [1:0]  bias_en;
  reg [2:0]  monitor_sel;
  reg [2:0]  gain_sel;
  reg [3:0]  rate_sel;
  reg [23:0] offset_coeff;
  reg [23:0] fullscale_coeff;
  reg        ready_mode;
  reg        trim_pending;
  reg [2:0]  data_ready_pin_state;
  reg [2:0]  shared_state;
  reg [7:0]  next_rdata;

  wire        wr_hit;
  wire        gain_change;
  wire [23:0] trim_data;
  wire [2:0]  next_data_ready_pin_state;
  wire [2:0]  next_shared_state;
  wire        forced_unity;
  wire        monitor_active;
  wire [2:0]  next_gain;

  assign wr_hit = core_ce_in & reg_wr_in;

  // Reload only on a real change of the gain field
  // detect gain change
  assign gain_change = wr_hit & (reg_addr_in == `ADCB_ADDR_GAINRATE) &
                       (reg_wdata_in[`ADCB_GAIN_MSB:`ADCB_GAIN_LSB] != gain_sel);

  assign forced_unity = (monitor_sel == `ADCB_MON_GAINCAL) |
                        (monitor_sel == `ADCB_MON_TEMP) |
                        monitor_sel[2];
  assign next_gain    = forced_unity ? 3'h0 : gain_sel;

  assign monitor_active = (monitor_sel != `ADCB_MON_NORMAL);

  assign next_data_ready_pin_state   = ready_next(data_ready_pin_state, conv_done_in, ready_clear_in);
  assign next_shared_state = ready_next(shared_state, conv_done_in, shared_clear_in);

  // ****************************************
  // Trim store
  // ****************************************
  adcb_trim_rom u_trim_rom
  (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .core_ce_in  (core_ce_in),
    .rd_en_in    (gain_change),
    .gain_in     (reg_wdata_in[`ADCB_GAIN_MSB:`ADCB_GAIN_LSB]),
    .trim_out    (trim_data)
  );

  // ****************************************
  // Oscillator flag synchroniser
  // ****************************************

  // Pin is asynchronous, two stages before use
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
    end
    else if (core_ce_in)
    begin
      osc_meta <= ext_osc_in;
      osc_sync <= osc_meta;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************

  // Reserved bits are not stored, so bad patterns are harmless
  // reserved bits dropped
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      burnout_sel     <= `ADCB_BURNOUT_RST;
      bias_en         <= `ADCB_BIAS_RST;
      monitor_sel     <= `ADCB_MONITOR_RST;
      gain_sel        <= `ADCB_GAIN_RST;
      rate_sel        <= `ADCB_RATE_RST;
      offset_coeff    <= `ADCB_OFC_RST;
      fullscale_coeff <= `ADCB_TRIM_G0;
      ready_mode      <= `ADCB_MODE_RST;
      trim_pending    <= 1'b0;
    end
    else if (core_ce_in)
    begin
      trim_pending <= gain_change;
      if (wr_hit)
      begin
        case (reg_addr_in)
          `ADCB_ADDR_BURNOUT:
            burnout_sel <= reg_wdata_in[`ADCB_BURNOUT_MSB:`ADCB_BURNOUT_LSB];
          `ADCB_ADDR_BIAS:
            bias_en <= reg_wdata_in[1:0];
          `ADCB_ADDR_MONITOR:
            monitor_sel <= reg_wdata_in[2:0];
          `ADCB_ADDR_GAINRATE:
          begin
            gain_sel <= reg_wdata_in[`ADCB_GAIN_MSB:`ADCB_GAIN_LSB];
            rate_sel <= reg_wdata_in[`ADCB_RATE_MSB:`ADCB_RATE_LSB];
          end
          `ADCB_ADDR_OFC_LOW:  offset_coeff[7:0]   <= reg_wdata_in;
          `ADCB_ADDR_OFC_MID:  offset_coeff[15:8]  <= reg_wdata_in;
          `ADCB_ADDR_OFC_HIGH: offset_coeff[23:16] <= reg_wdata_in;
          `ADCB_ADDR_FSC_LOW:  fullscale_coeff[7:0]   <= reg_wdata_in;
          `ADCB_ADDR_FSC_MID:  fullscale_coeff[15:8]  <= reg_wdata_in;
          `ADCB_ADDR_FSC_HIGH: fullscale_coeff[23:16] <= reg_wdata_in;
          `ADCB_ADDR_REVISION:
            ready_mode <= reg_wdata_in[`ADCB_MODE_BIT];
          default:
            ready_mode <= ready_mode;
        endcase
      end
      // Trim reload wins over a host write in the same cycle
      // reload full-scale
      if (trim_pending)
      begin
        fullscale_coeff <= trim_data;
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************

  // Unmapped offsets read as zero
  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr_in)
      `ADCB_ADDR_BURNOUT:  next_rdata = {burnout_sel, `ADCB_BURNOUT_FILL};
      `ADCB_ADDR_BIAS:     next_rdata = {6'h00, bias_en};
      `ADCB_ADDR_MONITOR:  next_rdata = {osc_sync, 4'h0, monitor_sel};
      `ADCB_ADDR_GAINRATE: next_rdata = {1'b0, gain_sel, rate_sel};
      `ADCB_ADDR_OFC_LOW:  next_rdata = offset_coeff[7:0];
      `ADCB_ADDR_OFC_MID:  next_rdata = offset_coeff[15:8];
      `ADCB_ADDR_OFC_HIGH: next_rdata = offset_coeff[23:16];
      `ADCB_ADDR_FSC_LOW:  next_rdata = fullscale_coeff[7:0];
      `ADCB_ADDR_FSC_MID:  next_rdata = fullscale_coeff[15:8];
      `ADCB_ADDR_FSC_HIGH: next_rdata = fullscale_coeff[23:16];
      `ADCB_ADDR_REVISION: next_rdata = {REVISION, ready_mode, 3'h0};
      default:             next_rdata = 8'h00;
    endcase
  end

  // Read data held until the next read
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      reg_rdata_out <= 8'h00;
    end
    else if (core_ce_in && reg_rd_in)
    begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ****************************************
  // Ready pin sequencing
  // ****************************************

  // Two sequencers, as the pins are released by different events
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      data_ready_pin_state   <= ST_IDLE;
      shared_state <= ST_IDLE;
    end
    else if (core_ce_in)
    begin
      data_ready_pin_state   <= next_data_ready_pin_state;
      shared_state <= next_shared_state;
    end
  end

  // Pin drivers
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      data_ready_pin_n_out           <= 1'b1;
      shared_output_ready_pin_out    <= 1'b1;
      shared_output_ready_pin_oe_out <= 1'b0;
    end
    else if (core_ce_in)
    begin
      data_ready_pin_n_out <= ready_level(next_data_ready_pin_state);
      // Pin floats while the port is deselected
      shared_output_ready_pin_oe_out <= cs_active_in;
      if (ready_mode && !shift_active_in)
        shared_output_ready_pin_out <= ready_level(next_shared_state);
      else
        shared_output_ready_pin_out <= dout_data_in;
    end
  end

  // ****************************************
  // Front end control outputs
  // ****************************************

  // Decoded one cycle after the register changes
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      burnout_current_select_out <= `ADCB_BURNOUT_RST;
      burnout_current_na_out     <= 14'h0000;
      midsupply_bias_enable_out  <= `ADCB_BIAS_RST;
      input_connection_out       <= 4'h1;
      effective_gain_code_out    <= `ADCB_GAIN_RST;
      gain_factor_out            <= 8'h01;
      output_rate_select_out     <= `ADCB_RATE_RST;
      output_rate_sps_out        <= 11'h005;
      offset_coefficient_out     <= `ADCB_OFC_RST;
      fullscale_coefficient_out  <= `ADCB_TRIM_G0;
    end
    else if (core_ce_in)
    begin
      burnout_current_select_out <= burnout_sel;
      case (burnout_sel)
        2'h1:    burnout_current_na_out <= 14'h01F4;
        2'h2:    burnout_current_na_out <= 14'h07D0;
        2'h3:    burnout_current_na_out <= 14'h2710;
        default: burnout_current_na_out <= 14'h0000;
      endcase
      midsupply_bias_enable_out <= monitor_active ? 2'h0 : bias_en;
      case (monitor_sel)
        `ADCB_MON_NORMAL:  input_connection_out <= 4'h1;
        `ADCB_MON_OFFSET:  input_connection_out <= 4'h2;
        `ADCB_MON_GAINCAL: input_connection_out <= 4'h4;
        `ADCB_MON_TEMP:    input_connection_out <= 4'h8;
        default:           input_connection_out <= 4'h0;
      endcase
      effective_gain_code_out <= next_gain;
      gain_factor_out <= 8'h01 << next_gain;
      if (rate_sel > `ADCB_RATE_MAX_CODE)
        output_rate_select_out <= `ADCB_RATE_MAX_CODE;
      else
        output_rate_select_out <= rate_sel;
      output_rate_sps_out       <= rate_sps(rate_sel);
      offset_coefficient_out    <= offset_coeff;
      fullscale_coefficient_out <= fullscale_coeff;
    end
  end

endmodule

`default_nettype wire

//--- verification/adcb_register_bank_asserts.sv
`include "adcb_defs.vh"
`default_nettype none

// ****************************************
// Register bank port checker
// ****************************************
module adcb_register_bank_asserts
#(
  parameter logic [3:0] REVISION = `ADCB_REVISION_CODE  // Arbitrary value
)
(
  // Clock, reset and register port
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        reg_rd_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [7:0]  reg_rdata_out,
  // Ready and shared pin inputs
  input wire logic        conv_done_in,
  input wire logic        shift_active_in,
  input wire logic        dout_data_in,
  // Pins and decoded settings
  input wire logic        data_ready_pin_n_out,
  input wire logic        shared_output_ready_pin_out,
  input wire logic [1:0]  burnout_current_select_out,
  input wire logic [13:0] burnout_current_na_out,
  input wire logic [1:0]  midsupply_bias_enable_out,
  input wire logic [3:0]  input_connection_out,
  input wire logic [2:0]  effective_gain_code_out,
  input wire logic [7:0]  gain_factor_out,
  input wire logic [3:0]  output_rate_select_out,
  input wire logic [10:0] output_rate_sps_out,
  input wire logic [23:0] offset_coefficient_out,
  input wire logic [23:0] fullscale_coefficient_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Rate table; below 1000 the rate simply doubles from 5
  function automatic logic [10:0] rate_sps(input logic [3:0] code);
    rate_sps = (code > 4'h8) ? 11'h7D0 : (code == 4'h8) ? 11'h3E8 : 11'h005 << code;
  endfunction

  property p_reset_values;
    $rose(rst_n_in) |-> offset_coefficient_out == 24'h000000 && data_ready_pin_n_out
      && fullscale_coefficient_out == `ADCB_TRIM_G0;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad values after reset");
  property p_burnout_current;
    burnout_current_na_out == (burnout_current_select_out == 2'h0 ? 14'h0000 :
      burnout_current_select_out == 2'h1 ? 14'h01F4 :
      burnout_current_select_out == 2'h2 ? 14'h07D0 : 14'h2710);
  endproperty
  a_burnout_current: assert property (p_burnout_current) else $error("burnout current");
  property p_gain_factor;
    gain_factor_out == 8'h01 << effective_gain_code_out;
  endproperty
  a_gain_factor: assert property (p_gain_factor) else $error("gain factor");
  property p_rate_table;
    output_rate_sps_out == rate_sps(output_rate_select_out) && output_rate_select_out <= 4'h9;
  endproperty
  a_rate_table: assert property (p_rate_table) else $error("output rate");
  property p_monitor_bias;
    !input_connection_out[0] |-> midsupply_bias_enable_out == 2'h0;
  endproperty
  a_monitor_bias: assert property (p_monitor_bias) else $error("bias under monitor");
  property p_monitor_gain;
    (input_connection_out[2] || input_connection_out[3]) |-> effective_gain_code_out == 3'h0;
  endproperty
  a_monitor_gain: assert property (p_monitor_gain) else $error("gain not forced");
  property p_ready_low;
    conv_done_in && data_ready_pin_n_out |=> !data_ready_pin_n_out;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready pin not low");
  property p_ready_pulse;
    conv_done_in && !data_ready_pin_n_out |=> data_ready_pin_n_out ##1 !data_ready_pin_n_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("no ready pulse");
  property p_shared_data;
    shift_active_in |=> shared_output_ready_pin_out == $past(dout_data_in);
  endproperty
  a_shared_data: assert property (p_shared_data) else $error("shared pin data");
  property p_revision_read;
    reg_rd_in && reg_addr_in == 4'hA |=> reg_rdata_out[7:4] == REVISION;
  endproperty
  a_revision_read: assert property (p_revision_read) else $error("revision read");

  // Main scenarios reached
  c_ready_pulse: cover property (conv_done_in && !data_ready_pin_n_out);
  c_temp_monitor: cover property (input_connection_out == 4'h8);
  c_max_rate: cover property (output_rate_sps_out == 11'h7D0);
endmodule

bind adcb_register_bank adcb_register_bank_asserts #(.REVISION(REVISION))
  u_adcb_register_bank_asserts
(
  .core_clk_in, .rst_n_in, .reg_rd_in, .reg_addr_in, .reg_rdata_out, .conv_done_in,
  .shift_active_in, .dout_data_in, .data_ready_pin_n_out, .shared_output_ready_pin_out,
  .burnout_current_select_out, .burnout_current_na_out, .midsupply_bias_enable_out,
  .input_connection_out, .effective_gain_code_out, .gain_factor_out,
  .output_rate_select_out, .output_rate_sps_out, .offset_coefficient_out,
  .fullscale_coefficient_out
);

`default_nettype wire

//--- verification/adcb_host_model.sv
`default_nettype none

// ****************************************
// Host side of the register port
// ****************************************
module adcb_host_model
(
  // Clock
  input  wire logic       core_clk_in,
  // Register access
  output var  logic       reg_wr_out,
  output var  logic       reg_rd_out,
  output var  logic [3:0] reg_addr_out,
  output var  logic [7:0] reg_wdata_out,
  input  wire logic [7:0] reg_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle port at time zero
  initial
  begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 4'h0;
    reg_wdata_out = 8'h00;
  end

  function automatic logic [7:0] fixed_bits(input logic [3:0] addr, input logic [7:0] data);
    case (addr)
      4'h0: fixed_bits = {data[7:6], 6'h01};
      4'h1: fixed_bits = {6'h00, data[1:0]};
      4'h2: fixed_bits = {5'h00, data[2:0]};
      4'h3: fixed_bits = {1'b0, data[6:0]};
      4'hA: fixed_bits = {data[7:3], 3'h0};
      default: fixed_bits = data;
    endcase
  endfunction

  // One-cycle write strobe, taken at the following edge
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    @(posedge core_clk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= addr;
    reg_wdata_out <= fixed_bits(addr, data);
    @(posedge core_clk_in);
    reg_wr_out <= 1'b0;
  endtask

  // Read data settles after the taking edge, so sample mid-cycle
  task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
    @(posedge core_clk_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= addr;
    @(posedge core_clk_in);
    reg_rd_out <= 1'b0;
    @(negedge core_clk_in);
    data = reg_rdata_in;
  endtask
endmodule

`default_nettype wire

//--- verification/adcb_register_bank_test.sv
`include "adcb_defs.vh"
`default_nettype none

`define CHECK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp); \
    end \
  end

// ****************************************
// Register bank testbench
// ****************************************
module adcb_register_bank_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk_in, rst_n_in, core_ce_in, ext_osc_in, conv_done_in;
  logic        ready_clear_in, shared_clear_in, cs_active_in, shift_active_in, dout_data_in;
  logic        reg_wr, reg_rd, data_ready_pin_n_out, shared_output_ready_pin_out, shared_oe;
  logic [3:0]  reg_addr, input_connection_out, output_rate_select_out;
  logic [7:0]  reg_wdata, reg_rdata, gain_factor_out;
  logic [1:0]  burnout_current_select_out, midsupply_bias_enable_out;
  logic [13:0] burnout_current_na_out;
  logic [2:0]  effective_gain_code_out;
  logic [10:0] output_rate_sps_out;
  logic [23:0] offset_coefficient_out, fullscale_coefficient_out;
  int          n_fail, n_compared, cycle_count;

  adcb_register_bank u_adcb_register_bank
  (
    .core_clk_in, .rst_n_in, .core_ce_in, .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .ext_osc_in,
    .conv_done_in, .ready_clear_in, .shared_clear_in, .cs_active_in, .shift_active_in,
    .dout_data_in, .data_ready_pin_n_out, .shared_output_ready_pin_out,
    .shared_output_ready_pin_oe_out(shared_oe), .burnout_current_select_out,
    .burnout_current_na_out, .midsupply_bias_enable_out, .input_connection_out,
    .effective_gain_code_out, .gain_factor_out, .output_rate_select_out, .output_rate_sps_out,
    .offset_coefficient_out, .fullscale_coefficient_out
  );

  adcb_host_model u_adcb_host_model
  (
    .core_clk_in(core_clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata)
  );

  // 40 ns clock
  initial
  begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  // Ceiling far above the few hundred cycles the tests need
  always @(posedge core_clk_in)
  begin
    cycle_count++;
    if (cycle_count == 20000)
    begin
      n_fail++;
      $display("[FAIL] t=%0t timeout", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Decoded outputs lag a write by up to two edges
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_adcb_host_model.write_reg(a, d);
  endtask

  task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_adcb_host_model.read_reg(a, d);
    `CHECK(d, exp)
  endtask

  // One conversion done pulse, returns after the taking edge
  task automatic conv_pulse();
    @(posedge core_clk_in);
    conv_done_in <= 1'b1;
    @(posedge core_clk_in);
    conv_done_in <= 1'b0;
    @(negedge core_clk_in);
  endtask

  task automatic t_reset_values();
    logic [23:0] trim;
    trim = `ADCB_TRIM_G0;
    `CHECK(input_connection_out, 4'h1)
    `CHECK(output_rate_sps_out, 11'h005)
    rd_check(4'h0, 8'h01);
    for (int a = 1; a < 7; a++)
      rd_check(a[3:0], 8'h00);
    rd_check(4'h7, trim[7:0]);
    rd_check(4'h9, trim[23:16]);
    rd_check(4'hA, {`ADCB_REVISION_CODE, 4'h0});
    rd_check(4'hF, 8'h00);
    $display("test reset values done");
  endtask

  task automatic t_burnout();
    logic [13:0] na [0:3];
    na = '{14'h0000, 14'h01F4, 14'h07D0, 14'h2710};
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h0, {i[1:0], 6'h00});
      settle(2);
      `CHECK(burnout_current_na_out, na[i])
      rd_check(4'h0, {i[1:0], 6'h01});
    end
    $display("test burnout done");
  endtask

  task automatic t_gain_rate();
    for (int i = 0; i < 16; i++)
    begin
      wr(4'h3, {1'b0, i[2:0], i[3:0]});
      settle(3);
      `CHECK(gain_factor_out, 8'h01 << i[2:0])
      `CHECK(output_rate_sps_out, i > 8 ? 11'h7D0 : i == 8 ? 11'h3E8 : 11'h005 << i)
    end
    $display("test gain and rate done");
  endtask

  task automatic t_calibration();
    wr(4'h4, 8'hA1);
    wr(4'h5, 8'hB2);
    wr(4'h6, 8'hC3);
    wr(4'h7, 8'h12);
    wr(4'h8, 8'h34);
    wr(4'h9, 8'h56);
    settle(2);
    `CHECK(offset_coefficient_out, 24'hC3B2A1)
    `CHECK(fullscale_coefficient_out, 24'h563412)
    // Same gain, new rate: no reload
    wr(4'h3, 8'h70);
    settle(3);
    `CHECK(fullscale_coefficient_out, 24'h563412)
    wr(4'h3, 8'h10);
    settle(3);
    `CHECK(fullscale_coefficient_out, `ADCB_TRIM_G1)
    $display("test calibration done");
  endtask

  task automatic t_monitor();
    wr(4'h1, 8'h03);
    wr(4'h3, 8'h30);
    for (int m = 0; m < 5; m++)
    begin
      wr(4'h2, m[7:0]);
      settle(2);
      `CHECK(input_connection_out, 4'h1 << m)
      `CHECK(midsupply_bias_enable_out, m == 0 ? 2'h3 : 2'h0)
      `CHECK(effective_gain_code_out, m > 1 ? 3'h0 : 3'h3)
    end
    wr(4'h2, 8'h01);
    settle(2);
    `CHECK(effective_gain_code_out, 3'h3)
    @(posedge core_clk_in);
    ext_osc_in <= 1'b1;
    settle(5);
    rd_check(4'h2, 8'h81);
    $display("test monitor done");
  endtask

  task automatic t_ready_pins();
    wr(4'hA, 8'hF8);
    rd_check(4'hA, {`ADCB_REVISION_CODE, 4'h8});
    conv_pulse();
    `CHECK({data_ready_pin_n_out, shared_output_ready_pin_out}, 2'h0)
    conv_pulse();
    `CHECK({data_ready_pin_n_out, shared_output_ready_pin_out}, 2'h3)
    settle(0);
    `CHECK({data_ready_pin_n_out, shared_output_ready_pin_out}, 2'h0)
    @(posedge core_clk_in);
    shift_active_in <= 1'b1;
    ready_clear_in <= 1'b1;
    shared_clear_in <= 1'b1;
    @(posedge core_clk_in);
    shift_active_in <= 1'b0;
    dout_data_in <= 1'b1;
    ready_clear_in <= 1'b0;
    shared_clear_in <= 1'b0;
    settle(0);
    `CHECK({data_ready_pin_n_out, shared_output_ready_pin_out}, 2'h2)
    settle(0);
    `CHECK({data_ready_pin_n_out, shared_output_ready_pin_out, shared_oe}, 3'h7)
    wr(4'hA, 8'h00);
    conv_pulse();
    `CHECK({data_ready_pin_n_out, shared_output_ready_pin_out}, 2'h1)
    $display("test ready pins done");
  endtask

  // Main sequence
  initial
  begin
    core_ce_in = 1'b1;
    cs_active_in = 1'b1;
    {ext_osc_in, conv_done_in, ready_clear_in, shared_clear_in} = 4'h0;
    {shift_active_in, dout_data_in} = 2'h0;
    rst_n_in = 1'b0;
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(negedge core_clk_in);
    t_reset_values();
    t_burnout();
    t_gain_rate();
    t_calibration();
    t_monitor();
    t_ready_pins();
    complete_run();
  end
endmodule

`default_nettype wire
